// File: src/blsfe_front_end.sv
/*
 Serial front end of a resident boot loader: async port with rate
 detection and a mode-3 SPI slave, locked to whichever is used first.
 Assumes pins are synchronous to mclk_i and the packet layer sits on the
 user byte streams.
*/
// Contract
// - After the first port is used, the other is ignored until reset or handoff.
// - Async characters are 8 data bits, no parity, one stop bit.
// - The async receiver samples sixteen times per bit at most rate.
// - The sync pattern edges are timed to set the async divisor.
// - After rate detection one 0xcc byte goes out at the new rate.
// - All logic runs from the crystal clock without a multiplier.
// - The sync port uses clock phase one and clock polarity one.
// - The sync port takes bit timing from the host clock, no detection.
// - Byte streams look the same to the user whichever port is in use.
// - First non-zero reply byte to a packet is 0xcc or 0x33.
// - Zero bytes are idle padding and dropped before a meaningful byte.
module blsfe_front_end (
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     handoff_i,
  input  wire logic                     uart_rx_i,
  output logic                          uart_tx_o,
  input  wire logic                     spi_sclk_i,
  input  wire logic                     spi_csn_i,
  input  wire logic                     spi_mosi_i,
  output logic                          spi_miso_o,
  output logic                          spi_miso_oe_o,
  output blsfe_pkg::blsfe_byte_type     rx_byte_o,
  input  wire blsfe_pkg::blsfe_byte_type tx_byte_i,
  output logic                          tx_ready_o,
  output blsfe_pkg::blsfe_port_type     port_o,
  output logic                          synced_o
);
  import blsfe_pkg::*;

  blsfe_port_type port_q;
  blsfe_ab_type   ab_q;
  logic [19:0]    div_q;
  logic [19:0]    cnt_q;
  logic [3:0]     edges_q;
  logic           rx_prev_q, sclk_prev_q;
  logic           payload_q;
  logic [7:0]     rx_byte_d;
  logic           rx_byte_v;

  ////////////////////////////////////////////////////////////////////////
  // Port selection, first activity wins, released by reset or handoff_i
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      port_q <= BLSFE_PORT_NONE;
    end else if (handoff_i) begin
      port_q <= BLSFE_PORT_NONE; // Loaded code owns the pins now
    end else if (port_q == BLSFE_PORT_NONE) begin
      if (!spi_csn_i) begin
        port_q <= BLSFE_PORT_SYNC;
      end else if (!uart_rx_i) begin
        port_q <= BLSFE_PORT_ASYNC;
      end
    end
  end
  wire async_on = (port_q == BLSFE_PORT_ASYNC) && !handoff_i;
  wire sync_on  = (port_q == BLSFE_PORT_SYNC)  && !handoff_i;

  ////////////////////////////////////////////////////////////////////////
  // Edge history on both lines
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rx_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b1;
    end else begin
      rx_prev_q   <= uart_rx_i;
      sclk_prev_q <= spi_sclk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate detection: 0x55 0x55 gives a falling edge every two bit times.
  // The first edge only locks the port, so timing runs from the second to
  // the tenth falling edge, 16 bits, and the divisor is count / 256.
  wire rx_fall = rx_prev_q && !uart_rx_i;
  logic tx_busy;
  logic ack_go;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ab_q    <= BLSFE_AB_IDLE;
      cnt_q   <= '0;
      edges_q <= '0;
      div_q   <= DIV_RST;
    end else begin
      case (ab_q)
        BLSFE_AB_IDLE: begin
          if (async_on && rx_fall) begin
            ab_q    <= BLSFE_AB_MEAS;
            cnt_q   <= 20'h00001; // Edge cycle counts as the first
            edges_q <= '0;
          end
        end
        BLSFE_AB_MEAS: begin
          cnt_q <= cnt_q + 20'h00001;
          if (rx_fall) begin
            edges_q <= edges_q + 4'h1;
            if (edges_q == 4'(SYNC_EDGES - 1)) begin
              // Floor keeps the tick counters from stalling on a glitch
              div_q <= ((cnt_q >> 8) < DIV_MIN) ? DIV_MIN : (cnt_q >> 8);
              ab_q  <= BLSFE_AB_ACK;
            end
          end
        end
        BLSFE_AB_ACK: begin
          if (!tx_busy) begin
            ab_q <= BLSFE_AB_RUN;
          end
        end
        BLSFE_AB_RUN: ab_q <= BLSFE_AB_RUN;
        default: ab_q <= BLSFE_AB_IDLE;
      endcase
    end
  end
  assign ack_go   = (ab_q == BLSFE_AB_ACK) && !tx_busy;
  assign synced_o = (ab_q == BLSFE_AB_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Async receiver, 16x oversampled, 8N1
  logic [19:0] rdiv_q;
  logic [3:0]  rph_q;
  logic [3:0]  rbit_q;
  logic        rbusy_q;
  logic [7:0]  rsh_q;
  logic        arx_v;
  logic [7:0]  arx_d;
  wire rtick = (rdiv_q == div_q - 20'h00001);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdiv_q <= '0; rph_q <= '0; rbit_q <= '0; rbusy_q <= 1'b0;
      rsh_q <= '0; arx_v <= 1'b0; arx_d <= '0;
    end else begin
      arx_v <= 1'b0;
      if (!rbusy_q) begin
        if (synced_o && rx_fall) begin
          rbusy_q <= 1'b1; rdiv_q <= '0; rph_q <= '0; rbit_q <= '0;
        end
      end else begin
        rdiv_q <= rtick ? '0 : rdiv_q + 20'h00001;
        if (rtick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == 4'h7) begin // Mid-bit sample
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h0 && uart_rx_i) begin
              rbusy_q <= 1'b0; // False start
            end else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) begin
              rsh_q <= {uart_rx_i, rsh_q[7:1]}; // LSB first
            end else if (rbit_q == 4'h9) begin
              rbusy_q <= 1'b0;
              arx_v   <= uart_rx_i; // bad stop bit drops byte
              arx_d   <= rsh_q;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Async transmitter, 16 ticks per bit
  logic [19:0] tdiv_q;
  logic [3:0]  tph_q;
  logic [3:0]  tbit_q;
  logic [9:0]  tsh_q;
  logic        tbusy_q;
  wire         tx_take = tx_byte_i.valid && tx_ready_o;
  assign tx_busy = tbusy_q;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tdiv_q <= '0; tph_q <= '0; tbit_q <= '0; tsh_q <= 10'h3ff;
      tbusy_q <= 1'b0;
    end else if (!tbusy_q) begin
      if (ack_go || (async_on && synced_o && tx_take)) begin
        tsh_q   <= {1'b1, (ack_go ? ACK_BYTE : tx_byte_i.data), 1'b0};
        tbusy_q <= 1'b1; tdiv_q <= '0; tph_q <= '0; tbit_q <= '0;
      end
    end else begin
      tdiv_q <= (tdiv_q == div_q - 20'h00001) ? '0 : tdiv_q + 20'h00001;
      if (tdiv_q == div_q - 20'h00001) begin
        tph_q <= tph_q + 4'h1;
        if (tph_q == 4'hf) begin
          tsh_q  <= {1'b1, tsh_q[9:1]};
          tbit_q <= tbit_q + 4'h1;
          if (tbit_q == 4'h9) begin
            tbusy_q <= 1'b0;
          end
        end
      end
    end
  end
  assign uart_tx_o = tsh_q[0];

  ////////////////////////////////////////////////////////////////////////
  // SPI slave mode 3: shift out on falling, sample on rising sclk
  logic [7:0] srx_q, stx_q;
  logic [2:0] sbit_q;
  logic       stx_full_q;
  logic [7:0] stx_hold_q;
  logic       srx_v;
  wire s_rise = !sclk_prev_q && spi_sclk_i;
  wire s_fall = sclk_prev_q && !spi_sclk_i;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      srx_q <= '0; stx_q <= '0; sbit_q <= '0; srx_v <= 1'b0;
      stx_full_q <= 1'b0; stx_hold_q <= '0;
    end else begin
      srx_v <= 1'b0;
      if (!sync_on || spi_csn_i) begin
        sbit_q <= '0;
      end else begin
        if (s_fall && sbit_q == 3'h0) begin
          // Empty holding register sends idle zeros
          stx_q <= stx_full_q ? stx_hold_q : IDLE_BYTE;
          stx_full_q <= 1'b0;
        end else if (s_fall) begin
          stx_q <= {stx_q[6:0], 1'b0};
        end
        if (s_rise) begin
          srx_q  <= {srx_q[6:0], spi_mosi_i}; // MSB first
          sbit_q <= sbit_q + 3'h1;
          srx_v  <= (sbit_q == 3'h7);
        end
      end
      // Last so a take on the load edge keeps its byte for the next slot
      if (sync_on && tx_take) begin
        stx_hold_q <= tx_byte_i.data; stx_full_q <= 1'b1;
      end
    end
  end
  assign spi_miso_o    = stx_q[7];
  assign spi_miso_oe_o = sync_on && !spi_csn_i;
  assign tx_ready_o    = async_on ? (synced_o && !tbusy_q)
                                  : (sync_on && !stx_full_q);

  ////////////////////////////////////////////////////////////////////////
  // Merge to one user stream, dropping leading idle zeros
  assign rx_byte_d = srx_v ? srx_q : arx_d;
  assign rx_byte_v = srx_v || arx_v;
  wire   rx_zero   = (rx_byte_d == IDLE_BYTE);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      payload_q <= 1'b0;
      rx_byte_o <= '0;
    end else begin
      rx_byte_o.valid <= rx_byte_v && (payload_q || !rx_zero);
      if (tx_take) payload_q <= 1'b0; // Reply sent, next packet starts
      if (rx_byte_v) begin
        rx_byte_o.data <= rx_byte_d;
        if (!rx_zero) payload_q <= 1'b1;
      end
    end
  end
  assign port_o = port_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_LOCK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (port_q != BLSFE_PORT_NONE && !handoff_i) |=> port_q == $past(port_q))
    else $error("port selection changed");
  AST_ACK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ack_go |=> tbusy_q && tsh_q[8:1] == ACK_BYTE)
    else $error("ack byte not loaded");
  AST_DIV: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    div_q >= DIV_MIN) else $error("divisor below floor");
  AST_MISO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    spi_csn_i |-> !spi_miso_oe_o) else $error("miso driven while deselected");
  AST_ZERO: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rx_byte_v && rx_zero && !payload_q) |=> !rx_byte_o.valid)
    else $error("leading zero passed");
  AST_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (port_q == BLSFE_PORT_NONE && !handoff_i && !spi_csn_i) |=> port_q == BLSFE_PORT_SYNC)
    else $error("sync select missed");
  AST_TXIDLE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !tbusy_q |-> uart_tx_o) else $error("tx line not idle high");
  AST_SYNCNOAB: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sync_on |-> ab_q == BLSFE_AB_IDLE) else $error("rate detect on sync port");
  COV_ASYNC: cover property (@(posedge mclk_i) synced_o);
  COV_SYNC:  cover property (@(posedge mclk_i) srx_v);
  COV_REPLY: cover property (@(posedge mclk_i) tx_take);
endmodule

// File: src/blsfe_pkg.sv
/*
 Constants and carrier types for the boot loader serial front end.
 Assumes a single 100 MHz crystal clock domain with no PLL.
*/
package blsfe_pkg;
  localparam int unsigned CLK_HZ        = 100000000;
  localparam int unsigned OVERSAMPLE    = 16;
  localparam logic [7:0]  SYNC_BYTE     = 8'h55;
  localparam logic [7:0]  ACK_BYTE      = 8'hcc;
  localparam logic [7:0]  NAK_BYTE      = 8'h33;
  localparam logic [7:0]  IDLE_BYTE     = 8'h00;
  localparam int unsigned SYNC_EDGES    = 8;
  localparam int unsigned SYNC_BITS     = 16;
  localparam logic [19:0] DIV_RST       = 20'h00010;
  localparam logic [19:0] DIV_MIN       = 20'h00001;

  typedef enum logic [1:0] {
    BLSFE_PORT_NONE  = 2'b00,
    BLSFE_PORT_ASYNC = 2'b01,
    BLSFE_PORT_SYNC  = 2'b11
  } blsfe_port_type;

  typedef enum logic [2:0] {
    BLSFE_AB_IDLE  = 3'b000,
    BLSFE_AB_MEAS  = 3'b001,
    BLSFE_AB_ACK   = 3'b011,
    BLSFE_AB_RUN   = 3'b010
  } blsfe_ab_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } blsfe_byte_type;
endpackage

// File: testbench/blsfe_host_model.sv
/*
 Host model: loader master on the async line and on the mode-3 SPI port.
 Assumes its tasks are called just after a rising mclk_i edge.
*/
module blsfe_host_model #(
  parameter int unsigned BIT_CLKS = 64,
  parameter int unsigned SCK_HALF = 8
) (
  input  wire logic mclk_i,
  input  wire logic uart_tx_i,
  input  wire logic spi_miso_i,
  input  wire logic spi_miso_oe_i,
  output logic      uart_rx_o,
  output logic      spi_sclk_o,
  output logic      spi_csn_o,
  output logic      spi_mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  logic miso_w;

  // Released miso shows the inverse of its last level, never a stale copy
  assign miso_w = spi_miso_oe_i ? spi_miso_i : ~last_q;
  always @(posedge mclk_i) begin
    last_q <= miso_w;
  end

  // Idle levels: line high, clock high between frames
  initial begin
    uart_rx_o  = 1'b1;
    spi_sclk_o = 1'b1;
    spi_csn_o  = 1'b1;
    spi_mosi_o = 1'b1;
    last_q     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wait_clks(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Stop level is an argument so a broken frame can be sent
  task automatic uart_send(input logic [7:0] b, input logic stop);
    uart_rx_o <= 1'b0;
    wait_clks(BIT_CLKS);
    for (int i = 0; i < 8; i++) begin
      uart_rx_o <= b[i];
      wait_clks(BIT_CLKS);
    end
    uart_rx_o <= stop;
    wait_clks(BIT_CLKS);
    // Good frames run back to back; a broken one returns the line to idle
    if (!stop) begin
      uart_rx_o <= 1'b1;
      wait_clks(BIT_CLKS);
    end
  endtask

  // Frame bits 7:0 data, bit 8 stop, sampled mid-bit
  task automatic uart_recv(input int limit, output logic seen, output logic [8:0] fr);
    int n;
    n = 0;
    seen = 1'b0;
    fr = '0;
    while (uart_tx_i !== 1'b0 && n < limit) begin
      @(posedge mclk_i);
      n++;
    end
    if (uart_tx_i === 1'b0) begin
      seen = 1'b1;
      wait_clks(BIT_CLKS / 2);
      for (int i = 0; i < 9; i++) begin
        wait_clks(BIT_CLKS);
        fr[i] = uart_tx_i;
      end
    end
  endtask

  // Pattern resent until answered, three tries at most
  task automatic uart_sync(output logic seen, output logic [8:0] fr);
    seen = 1'b0;
    for (int t = 0; t < 3; t++) begin
      if (seen !== 1'b1) begin
        fork
          begin
            uart_send(8'h55, 1'b1);
            uart_send(8'h55, 1'b1);
          end
          uart_recv(60 * BIT_CLKS, seen, fr);
        join
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic spi_select(input logic on);
    spi_csn_o <= ~on;
    wait_clks(SCK_HALF);
  endtask

  // Mode 3: drive on the falling edge, sample on the rising edge, MSB first
  task automatic spi_byte(input logic [7:0] mo, output logic [7:0] mi);
    for (int i = 7; i >= 0; i--) begin
      spi_sclk_o <= 1'b0;
      spi_mosi_o <= mo[i];
      wait_clks(SCK_HALF);
      spi_sclk_o <= 1'b1;
      mi[i] = miso_w;
      wait_clks(SCK_HALF);
    end
  endtask
endmodule

// File: testbench/blsfe_front_end_tb.sv
/*
 Testbench for the loader serial front end with a host model.
 Assumes one 100 MHz clock and the host model tasks.
*/
module blsfe_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import blsfe_pkg::*;
  logic           mclk_i;
  logic           rstn_i;
  logic           handoff;
  logic           uart_rx;
  logic           uart_tx;
  logic           sclk;
  logic           csn;
  logic           mosi;
  logic           miso;
  logic           miso_oe;
  logic           tx_ready;
  logic           synced;
  logic           seen;
  logic [8:0]     fr;
  blsfe_byte_type rx_byte;
  blsfe_byte_type tx_byte;
  blsfe_port_type port;
  int             num_errors;
  int             checks_done;
  logic [7:0]     got_q[$];

  blsfe_front_end i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .handoff_i(handoff),
    .uart_rx_i(uart_rx), .uart_tx_o(uart_tx), .spi_sclk_i(sclk), .spi_csn_i(csn),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .rx_byte_o(rx_byte),
    .tx_byte_i(tx_byte), .tx_ready_o(tx_ready), .port_o(port), .synced_o(synced));
  blsfe_host_model i_host (.mclk_i(mclk_i), .uart_tx_i(uart_tx), .spi_miso_i(miso),
    .spi_miso_oe_i(miso_oe), .uart_rx_o(uart_rx), .spi_sclk_o(sclk), .spi_csn_o(csn),
    .spi_mosi_o(mosi));

  // Clock and collection of received bytes
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (rx_byte.valid === 1'b1) got_q.push_back(rx_byte.data);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    got_q.delete();
  endtask

  // Valid held until the edge where ready is seen high
  task automatic send_reply(input logic [7:0] b);
    int n;
    n = 0;
    tx_byte <= '{valid: 1'b1, data: b};
    @(negedge mclk_i);
    while (tx_ready !== 1'b1 && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
    check(32'(tx_ready), 32'd1, "reply taken");
    @(posedge mclk_i);
    tx_byte <= '{valid: 1'b0, data: 8'h00};
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_async_sync();
    i_host.uart_sync(seen, fr);
    check(32'(seen), 32'd1, "ack seen");
    check(32'(fr), 32'({1'b1, ACK_BYTE}), "ack frame");
    check(32'(synced), 32'd1, "synced");
    check(32'(port), 32'(BLSFE_PORT_ASYNC), "port");
    $display("done async_sync");
  endtask

  // Leading zero dropped, bad stop dropped, SPI ignored while locked
  task automatic t_async_rx();
    logic [7:0] mi;
    i_host.uart_send(IDLE_BYTE, 1'b1);
    i_host.uart_send(8'ha5, 1'b1);
    i_host.uart_send(8'h5a, 1'b0);
    i_host.spi_select(1'b1);
    i_host.spi_byte(8'h81, mi);
    check(32'(miso_oe), 32'd0, "miso off");
    i_host.spi_select(1'b0);
    check(32'(got_q.size()), 32'd1, "rx count");
    check(32'(got_q[0]), 32'ha5, "rx data");
    check(32'(port), 32'(BLSFE_PORT_ASYNC), "port kept");
    $display("done async_rx");
  endtask

  task automatic t_async_tx();
    fork
      send_reply(NAK_BYTE);
      i_host.uart_recv(200, seen, fr);
    join
    check(32'(fr), 32'({1'b1, NAK_BYTE}), "tx frame");
    $display("done async_tx");
  endtask

  // Loaded code takes over: both ports released, SPI deaf and no reply path
  task automatic t_handoff();
    handoff <= 1'b1;
    i_host.wait_clks(2);
    check(32'(port), 32'(BLSFE_PORT_NONE), "port released");
    check(32'(tx_ready), 32'd0, "no reply path");
    i_host.spi_select(1'b1);
    check(32'(miso_oe), 32'd0, "miso off at handoff");
    check(32'(port), 32'(BLSFE_PORT_NONE), "no new lock");
    i_host.spi_select(1'b0);
    handoff <= 1'b0;
    $display("done handoff");
  endtask

  // Sync port after reset; async pattern then ignored
  task automatic t_spi();
    logic [7:0] mi;
    int n;
    n = 0;
    i_host.spi_select(1'b1);
    i_host.spi_byte(8'h3c, mi);
    i_host.wait_clks(4);
    check(32'(port), 32'(BLSFE_PORT_SYNC), "spi port");
    check(32'(got_q[0]), 32'h3c, "spi rx");
    check(32'(miso_oe), 32'd1, "miso on");
    send_reply(ACK_BYTE);
    mi = 8'h00;
    while (mi === 8'h00 && n < 3) begin
      i_host.spi_byte(IDLE_BYTE, mi);
      n++;
    end
    check(32'(mi), 32'(ACK_BYTE), "spi reply");
    i_host.spi_select(1'b0);
    check(32'(miso_oe), 32'd0, "miso released");
    i_host.uart_sync(seen, fr);
    check(32'(seen), 32'd0, "no ack");
    check(32'(synced), 32'd0, "not synced");
    $display("done spi");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog well above the roughly 16k cycles the tests need
  initial begin
    repeat (80000) @(posedge mclk_i);
    num_errors++;
    $display("mismatch at %0t: watchdog", $time);
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    tx_byte = '0;
    handoff = 1'b0;
    do_reset();
    t_async_sync();
    t_async_rx();
    t_async_tx();
    t_handoff();
    do_reset();
    t_spi();
    report_and_stop();
  end
endmodule
